// ===== hdl/dogc_pkg.sv
// Shared constants for the offset and gain correction link
package dogc_pkg;
   // ************************************************
   // Widths and counts
   // ************************************************
   localparam int CODE_W  = 16;
   localparam int OFF_W   = 14;
   localparam int OFF_REF = 16;
   localparam int NCH     = 8;
   localparam int CH_W    = 3;
   localparam int WORD_W  = 24;
   localparam int FRAME_W = 32;
   localparam int CNT_W   = 6;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 8;
   // ************************************************
   // Command word fields
   // ************************************************
   localparam int OP_MSB   = 23;
   localparam int CH_MSB   = 19;
   localparam int A0_POS   = 16;
   localparam int DATA_MSB = 15;
   localparam logic [3:0] OP_CODE = 4'h0;
   localparam logic [3:0] OP_OFF  = 4'h2;
   localparam logic [3:0] OP_GAIN = 4'h3;
   localparam logic [3:0] OP_READ = 4'h8;
   // ************************************************
   // Reset values and timing
   // ************************************************
   localparam logic [CODE_W-1:0] GAIN_RST = 16'h0000;
   localparam logic [OFF_W-1:0]  OFF_RST  = 14'h0000;
   localparam int HALF_CYC = 4;
   localparam int GAP_CYC  = 8;
   // ************************************************
   // Host register map
   // ************************************************
   localparam logic [ADDR_W-1:0] REG_CMD   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STAT  = 8'h08;
   localparam logic [ADDR_W-1:0] REG_RDATA = 8'h0c;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : dogc_pkg

// ===== hdl/dogc_link_if.sv
// Serial link between host controller and correction device
`timescale 1ns/1ps
`default_nettype none
interface dogc_link_if;
   logic cs_n;
   logic sck;
   logic sdi;
   logic sdo;
   modport host (output cs_n, output sck, output sdi, input sdo);
   modport dev  (input cs_n, input sck, input sdi, output sdo);
endinterface : dogc_link_if
`default_nettype wire

// ===== hdl/dogc_corrector.sv
// Gain multiply, offset add and clamp of one channel code
`timescale 1ns/1ps
`default_nettype none
module dogc_corrector import dogc_pkg::*; (
   input  wire logic [CODE_W-1:0] code,
   input  wire logic [CODE_W-1:0] gain,
   input  wire logic [OFF_W-1:0]  offset,
   output logic      [CODE_W-1:0] corr
);
   localparam int PW = 2*CODE_W+2;
   localparam int SW = CODE_W+3;
   // ************************************************
   // Gain stage
   // ************************************************
   // factor one plus signed gain
   wire logic [CODE_W+1:0] factor =
      {2'b01, {CODE_W{1'b0}}} + {{2{gain[CODE_W-1]}}, gain};
   wire logic [PW-1:0] prod =
      {{(CODE_W+2){1'b0}}, code} * {{CODE_W{1'b0}}, factor};
   wire logic signed [SW-1:0] scaled =
      $signed({2'b00, prod[2*CODE_W:CODE_W]});
   // ************************************************
   // Offset stage
   // ************************************************
   // offset at one LSB
   wire logic signed [SW-1:0] off_ext =
      $signed({{(SW-OFF_W){offset[OFF_W-1]}}, offset})
      >>> (OFF_REF-CODE_W);
   wire logic signed [SW-1:0] sum = scaled + off_ext;
   wire logic signed [SW-1:0] top_code =
      $signed({3'b000, {CODE_W{1'b1}}});
   always_comb begin
      if (sum[SW-1]) begin
         corr = {CODE_W{1'b0}};
      end else if (sum > top_code) begin
         corr = {CODE_W{1'b1}};
      end else begin
         corr = sum[CODE_W-1:0];
      end
   end
endmodule : dogc_corrector
`default_nettype wire

// ===== hdl/dogc_device.sv
// Device end: link receiver, correction tables and readback
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Offset spans 12.5 percent, one LSB step
// - Offset code is signed two's complement
// - Offset write: opcode 0010, channel, code
// - New offset waits for next code write
// - Readback 1000 returns code, eight zeros
// - Narrow variant pads twelve zero bits
// - Gain factor spans 0.5 to 1.5
// - Gain code signed, zero is unity
// - Host computes gain code from percent
// - Gain write: opcode 0011, sixteen bits
// - Narrow gain: twelve bits, four zeros
// - New gain waits for next code write
// - Multiply by gain, then add offset
// - Channel in bits 19 to 17, A0 zero
// - Read data leaves in next frame
// - CRC byte optional, 24-bit word allowed
module dogc_device import dogc_pkg::*; (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   dogc_link_if.dev               lnk,
   output logic                   adj_valid,
   output logic [CH_W-1:0]        adj_chan,
   output logic [CODE_W-1:0]      adj_code
);
   // ************************************************
   // Link clock domain
   // ************************************************
   logic [CNT_W-1:0]  rx_cnt_reg;
   logic [WORD_W-1:0] rx_sh_reg;
   logic [WORD_W-1:0] rx_word_reg;
   logic              rx_done_reg;
   logic [CNT_W-1:0]  tx_idx_reg;
   logic [FRAME_W-1:0] resp_reg;

   wire logic [WORD_W-1:0] rx_next =
      {rx_sh_reg[WORD_W-2:0], lnk.sdi};
   wire logic rx_last  = rx_cnt_reg == CNT_W'(WORD_W-1);
   wire logic rx_first = rx_cnt_reg == {CNT_W{1'b0}};
   wire logic rx_sat   = rx_cnt_reg == {CNT_W{1'b1}};
   wire logic tx_sat   = tx_idx_reg == {CNT_W{1'b1}};
   wire logic tx_live  = tx_idx_reg < CNT_W'(FRAME_W);
   wire logic [4:0] tx_sel =
      5'(FRAME_W-1) - tx_idx_reg[4:0];

   // Bit counter, cleared while deselected
   always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
      if (lnk.cs_n) begin
         rx_cnt_reg <= {CNT_W{1'b0}};
      end else if (!rx_sat) begin
         rx_cnt_reg <= rx_cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge lnk.sck) begin
      rx_sh_reg <= rx_next;
      if (rx_last) begin
         rx_word_reg <= rx_next;
      end
   end

   // Frame holds a full command word
   always_ff @(posedge lnk.sck) begin
      if (rx_first) begin
         rx_done_reg <= 1'b0;
      end else if (rx_last) begin
         rx_done_reg <= 1'b1;
      end
   end

   // Output bit index, advanced on falling edge
   always_ff @(negedge lnk.sck or posedge lnk.cs_n) begin
      if (lnk.cs_n) begin
         tx_idx_reg <= {CNT_W{1'b0}};
      end else if (!tx_sat) begin
         tx_idx_reg <= tx_idx_reg + CNT_W'(1);
      end
   end

   // previous answer shifts out
   // Held low while deselected
   assign lnk.sdo = ~lnk.cs_n & tx_live & resp_reg[tx_sel];

   // ************************************************
   // Frame end crossing
   // ************************************************
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
      end else begin
         cs_s1_reg <= lnk.cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
      end
   end

   wire logic frame_end = cs_s2_reg & ~cs_s3_reg;
   wire logic take      = frame_end & rx_done_reg;

   // ************************************************
   // Command decode
   // ************************************************
   // opcode in upper nibble
   wire logic [3:0] op = rx_word_reg[OP_MSB -: 4];
   wire logic [CH_W-1:0] ch = rx_word_reg[CH_MSB -: CH_W];
   wire logic a0 = rx_word_reg[A0_POS];
   wire logic hit = take & ~a0;
   wire logic [CODE_W-1:0] field =
      rx_word_reg[DATA_MSB -: CODE_W];
   wire logic [OFF_W-1:0] off_field =
      rx_word_reg[DATA_MSB -: OFF_W];

   wire logic wr_code = hit & (op == OP_CODE);
   wire logic wr_off  = hit & (op == OP_OFF);
   wire logic wr_gain = hit & (op == OP_GAIN);
   wire logic rd_corr = hit & (op == OP_READ);

   // ************************************************
   // Channel tables
   // ************************************************
   logic [OFF_W-1:0]  off_tab_reg  [NCH];
   logic [CODE_W-1:0] gain_tab_reg [NCH];
   logic [CODE_W-1:0] corr_tab_reg [NCH];
   logic [CODE_W-1:0] corr;

   dogc_corrector u_corr (
      .code   (field),
      .gain   (gain_tab_reg[ch]),
      .offset (off_tab_reg[ch]),
      .corr   (corr)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NCH; i++) begin
            off_tab_reg[i]  <= OFF_RST;
            gain_tab_reg[i] <= GAIN_RST;
            corr_tab_reg[i] <= {CODE_W{1'b0}};
         end
      end else begin
         if (wr_off) begin
            off_tab_reg[ch] <= off_field;
         end
         if (wr_gain) begin
            gain_tab_reg[ch] <= field;
         end
         if (wr_code) begin
            corr_tab_reg[ch] <= corr;
         end
      end
   end

   // ************************************************
   // Readback word and user output
   // ************************************************
   // code then zero bits
   wire logic [FRAME_W-1:0] resp_next = rd_corr ?
      {rx_word_reg[OP_MSB -: 8], corr_tab_reg[ch],
       {(WORD_W-CODE_W){1'b0}}} : {FRAME_W{1'b0}};

   logic              adj_valid_reg;
   logic [CH_W-1:0]   adj_chan_reg;
   logic [CODE_W-1:0] adj_code_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resp_reg <= {FRAME_W{1'b0}};
      end else if (take) begin
         resp_reg <= resp_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adj_valid_reg <= 1'b0;
         adj_chan_reg  <= {CH_W{1'b0}};
         adj_code_reg  <= {CODE_W{1'b0}};
      end else begin
         adj_valid_reg <= wr_code;
         if (wr_code) begin
            adj_chan_reg <= ch;
            adj_code_reg <= corr;
         end
      end
   end

   assign adj_valid = adj_valid_reg;
   assign adj_chan  = adj_chan_reg;
   assign adj_code  = adj_code_reg;
endmodule : dogc_device
`default_nettype wire

// ===== hdl/dogc_host.sv
// Host end: AXI4-Lite command registers and serial master
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dogc_host import dogc_pkg::*; (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   dogc_link_if.host              lnk
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_GAP
   } dogc_state_e;

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [3:0]        strb);
      logic [DATA_W-1:0] m;
      m = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return m;
   endfunction : merge

   // ************************************************
   // AXI4-Lite slave
   // ************************************************
   logic              awready_reg, wready_reg, bvalid_reg;
   logic              arready_reg, rvalid_reg;
   logic [1:0]        bresp_reg, rresp_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [DATA_W-1:0] w_data_reg, rdata_reg;
   logic [3:0]        w_strb_reg;
   logic [DATA_W-1:0] cmd_reg, ctrl_reg, rx_data_reg;
   dogc_state_e       state_reg;

   wire logic do_wr = ~awready_reg & ~wready_reg & ~bvalid_reg;
   wire logic wr_cmd  = do_wr & (aw_addr_reg == REG_CMD);
   wire logic wr_ctrl = do_wr & (aw_addr_reg == REG_CTRL);
   wire logic busy    = state_reg != ST_IDLE;
   wire logic start   = wr_cmd & ~busy;
   wire logic [DATA_W-1:0] cmd_next =
      merge(cmd_reg, w_data_reg, w_strb_reg);
   wire logic rd_hit = (araddr == REG_CMD) | (araddr == REG_CTRL)
      | (araddr == REG_STAT) | (araddr == REG_RDATA);
   wire logic [DATA_W-1:0] rd_mux =
      (araddr == REG_CMD)  ? cmd_reg :
      (araddr == REG_CTRL) ? ctrl_reg :
      (araddr == REG_STAT) ? {{(DATA_W-1){1'b0}}, busy} :
      (araddr == REG_RDATA) ? rx_data_reg : {DATA_W{1'b0}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OK;
         aw_addr_reg <= {ADDR_W{1'b0}};
         w_data_reg  <= {DATA_W{1'b0}};
         w_strb_reg  <= 4'h0;
      end else begin
         if (awvalid & awready_reg) begin
            awready_reg <= 1'b0;
            aw_addr_reg <= awaddr;
         end
         if (wvalid & wready_reg) begin
            wready_reg <= 1'b0;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_cmd | wr_ctrl) ? RESP_OK : RESP_ERR;
         end
         if (bvalid_reg & bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= {DATA_W{1'b0}};
         rresp_reg   <= RESP_OK;
      end else if (arvalid & arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_mux;
         rresp_reg   <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (rvalid_reg & rready) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_reg  <= {DATA_W{1'b0}};
         ctrl_reg <= {DATA_W{1'b0}};
      end else begin
         if (start) begin
            cmd_reg <= cmd_next;
         end
         if (wr_ctrl) begin
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg)
               & {{(DATA_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ************************************************
   // Serial master
   // ************************************************
   logic              sdo_s1_reg, sdo_s2_reg;
   logic              cs_n_reg, sck_reg, sdi_reg;
   logic [3:0]        div_reg;
   logic [CNT_W-1:0]  left_reg;
   logic [FRAME_W-1:0] tx_sh_reg, rx_sh_reg;

   wire logic half_end = div_reg == 4'(HALF_CYC-1);
   wire logic gap_end  = div_reg == 4'(GAP_CYC-1);
   wire logic [CNT_W-1:0] frame_len =
      ctrl_reg[0] ? CNT_W'(FRAME_W) : CNT_W'(WORD_W);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
      end else begin
         sdo_s1_reg <= lnk.sdo;
         sdo_s2_reg <= sdo_s1_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg   <= ST_IDLE;
         cs_n_reg    <= 1'b1;
         sck_reg     <= 1'b0;
         sdi_reg     <= 1'b0;
         div_reg     <= 4'h0;
         left_reg    <= {CNT_W{1'b0}};
         tx_sh_reg   <= {FRAME_W{1'b0}};
         rx_sh_reg   <= {FRAME_W{1'b0}};
         rx_data_reg <= {DATA_W{1'b0}};
      end else begin
         div_reg <= (state_reg == ST_IDLE) ? 4'h0 : div_reg + 4'h1;
         unique case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  cs_n_reg  <= 1'b0;
                  tx_sh_reg <= {cmd_next[WORD_W-1:0], 8'h00};
                  sdi_reg   <= cmd_next[WORD_W-1];
                  left_reg  <= frame_len;
                  state_reg <= ST_LEAD;
               end
            end
            ST_LEAD: begin
               if (half_end) begin
                  sck_reg   <= 1'b1;
                  div_reg   <= 4'h0;
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (half_end) begin
                  sck_reg   <= 1'b0;
                  div_reg   <= 4'h0;
                  rx_sh_reg <= {rx_sh_reg[FRAME_W-2:0], sdo_s2_reg};
                  tx_sh_reg <= {tx_sh_reg[FRAME_W-2:0], 1'b0};
                  sdi_reg   <= tx_sh_reg[FRAME_W-2];
                  left_reg  <= left_reg - CNT_W'(1);
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (half_end) begin
                  div_reg <= 4'h0;
                  if (left_reg == {CNT_W{1'b0}}) begin
                     cs_n_reg    <= 1'b1;
                     sdi_reg     <= 1'b0;
                     rx_data_reg <= ctrl_reg[0] ? rx_sh_reg :
                        {rx_sh_reg[WORD_W-1:0], 8'h00};
                     state_reg   <= ST_GAP;
                  end else begin
                     sck_reg   <= 1'b1;
                     state_reg <= ST_HIGH;
                  end
               end
            end
            ST_GAP: begin
               if (gap_end) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign lnk.cs_n = cs_n_reg;
   assign lnk.sck  = sck_reg;
   assign lnk.sdi  = sdi_reg;
   assign awready  = awready_reg;
   assign wready   = wready_reg;
   assign bvalid   = bvalid_reg;
   assign bresp    = bresp_reg;
   assign arready  = arready_reg;
   assign rvalid   = rvalid_reg;
   assign rdata    = rdata_reg;
   assign rresp    = rresp_reg;
endmodule : dogc_host
`default_nettype wire

// ===== test/dogc_properties.sv
// Link checker: timing and framing of the serial wire
`timescale 1ns/1ps
`default_nettype none
module dogc_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo
);
   // ********************************
   // Clock rise counter per frame
   // ********************************
   logic [5:0] rise_cnt;
   logic       sck_q;
   wire        sck_up = sck && !sck_q;

   always_ff @(posedge aclk) begin
      sck_q    <= sck;
      rise_cnt <= (!aresetn || cs_n) ? 6'h00 : rise_cnt + {5'h00, sck_up};
   end

   // ********************************
   // Wire properties
   // ********************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_high4;
      sck [*4] ##1 !sck;
   endsequence
   sequence s_low4;
      !sck [*4];
   endsequence
   sequence s_lead;
      !sck [*3] ##[1:5] sck;
   endsequence

   a_high_phase: assert property (
      $rose(sck) |-> s_high4) else $error("sck high phase wrong");
   a_low_phase: assert property (
      $fell(sck) |-> s_low4) else $error("sck low phase wrong");
   a_frame_lead: assert property (
      $fell(cs_n) |-> s_lead) else $error("first sck edge misplaced");
   a_idle_clock: assert property (
      cs_n |-> !sck) else $error("sck toggles outside frame");
   a_sdo_quiet: assert property (
      cs_n |-> !sdo) else $error("sdo driven outside frame");
   a_sdi_hold: assert property (
      (sck && $past(sck)) |-> $stable(sdi)) else $error("sdi moved in high");
   a_frame_len: assert property (
      $rose(cs_n) |-> (rise_cnt == 6'h18 || rise_cnt == 6'h20))
      else $error("frame bit count wrong");
   a_frame_gap: assert property (
      $rose(cs_n) |-> cs_n [*8]) else $error("gap between frames short");
   a_frame_span: assert property (
      $fell(cs_n) |-> ##[180:300] $rose(cs_n)) else $error("frame length bad");
endmodule : dogc_properties
`default_nettype wire

// ===== test/tb_dac_offset_gain_correction.sv
// Testbench: host and device joined over the serial link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_dac_offset_gain_correction import dogc_pkg::*;;
   typedef struct {logic [2:0] ch; logic [15:0] g; logic [13:0] o;
                   logic [15:0] c;} dogc_row_s;
   logic              aclk = 1'b0;
   logic              aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic              awready, wready, bvalid, arready, rvalid, adj_valid;
   logic [1:0]        bresp, rresp, r;
   logic [CH_W-1:0]   adj_chan, last_ch;
   logic [15:0]       adj_code, last_code, e;
   int                fails = 0, tests_run = 0, vcnt = 0, n;
   // gain codes are the gain fraction times 2^16
   dogc_row_s rows[5] = '{'{3'h0, 16'h0000, 14'h0000, 16'h1234},
                          '{3'h2, 16'h4000, 14'h0010, 16'h8000},
                          '{3'h5, 16'h8000, 14'h3fff, 16'h0000},
                          '{3'h7, 16'h7fff, 14'h1fff, 16'hffff},
                          '{3'h3, 16'hc000, 14'h2000, 16'h4000}};

   dogc_link_if lnk ();
   dogc_host dogc_host_inst (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .lnk(lnk));
   dogc_device dogc_device_inst (.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
      .adj_valid(adj_valid), .adj_chan(adj_chan), .adj_code(adj_code));
   dogc_properties dogc_properties_inst (.aclk(aclk), .aresetn(aresetn),
      .cs_n(lnk.cs_n), .sck(lnk.sck), .sdi(lnk.sdi), .sdo(lnk.sdo));

   always #2.5 aclk = ~aclk;

   always @(posedge aclk) begin
      if (adj_valid === 1'b1) begin
         vcnt++;
         last_ch   = adj_chan;
         last_code = adj_code;
      end
   end

   // ********************************
   // Helpers
   // ********************************
   function automatic logic [15:0] corr_f(input logic [15:0] c,
      input logic [15:0] g, input logic [13:0] o);
      longint v;
      v = ((longint'(c) * (longint'(65536) + longint'($signed(g)))) >>> 16)
          + longint'($signed(o));
      if (v < 0) v = 0;
      if (v > 65535) v = 65535;
      return v[15:0];
   endfunction : corr_f

   function automatic logic [23:0] cmd(input logic [3:0] op,
      input logic [2:0] ch, input logic [15:0] v);
      return {op, ch, 1'b0, v};
   endfunction : cmd

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] q);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= v;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      q = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] q);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      v = rdata;
      q = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic send(input logic [23:0] w);
      logic [31:0] s;
      logic [1:0]  q;
      axi_wr(REG_CMD, {8'h00, w}, q);
      do axi_rd(REG_STAT, s, q); while (s[0] !== 1'b0);
   endtask : send

   task automatic code_wr(input logic [2:0] ch, input logic [15:0] c,
      input logic [15:0] x);
      int k;
      k = vcnt;
      send(cmd(OP_CODE, ch, c));
      `CHK(vcnt, k + 1)
      `CHK(last_ch, ch)
      `CHK(last_code, x)
   endtask : code_wr

   task automatic rd_back(input logic [2:0] ch, input logic [15:0] x);
      send(cmd(OP_READ, ch, 16'h0000));
      send(cmd(OP_READ, ch, 16'h0000));
      axi_rd(REG_RDATA, d, r);
      `CHK(d, {OP_READ, ch, 1'b0, x, 8'h00})
   endtask : rd_back

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata} = '0;
      do_reset;
      foreach (rows[i]) begin
         e = corr_f(rows[i].c, rows[i].g, rows[i].o);
         send(cmd(OP_GAIN, rows[i].ch, rows[i].g));
         send(cmd(OP_OFF, rows[i].ch, {rows[i].o, 2'b00}));
         code_wr(rows[i].ch, rows[i].c, e);
         rd_back(rows[i].ch, e);
         $display("test row %0d finished", i);
      end
      code_wr(3'h1, 16'h1111, 16'h1111);
      send(cmd(OP_GAIN, 3'h1, 16'h4000));
      send(cmd(OP_OFF, 3'h1, 16'h0010));
      rd_back(3'h1, 16'h1111);
      code_wr(3'h1, 16'h1111, 16'h1559);
      $display("test deferred update finished");
      n = vcnt;
      send({OP_CODE, 4'h3, 16'h2222});
      `CHK(vcnt, n)
      $display("test odd address finished");
      axi_wr(REG_CTRL, 32'h00000001, r);
      axi_rd(REG_CTRL, d, r);
      `CHK(d[0], 1'b1)
      code_wr(3'h4, 16'h0abc, 16'h0abc);
      axi_wr(REG_CTRL, 32'h00000000, r);
      $display("test long frame finished");
      axi_wr(8'h10, 32'h0000005a, r);
      `CHK(r, RESP_ERR)
      axi_rd(8'h10, d, r);
      `CHK(r, RESP_ERR)
      $display("test unmapped finished");
      do_reset;
      code_wr(3'h2, 16'h8000, 16'h8000);
      $display("test second reset finished");
      finish_test;
   end

   initial begin
      repeat (40000) @(posedge aclk);
      fails++;
      finish_test;
   end
endmodule : tb_dac_offset_gain_correction
`default_nettype wire
